// ---- logic/vlan_qos_pkg.sv ----
`default_nettype none
package vlan_qos_pkg;
   // port and queue geometry
   localparam int NUM_PORTS = 18;
   localparam int PORT_W = 5;
   localparam int NUM_QUEUES = 8;
   localparam int QUEUE_W = 3;
   // queues at or above this index form the high priority class
   localparam logic [2:0] HIGH_BASE = 3'h4;
   // priority value at or above which a tag or DS field counts as high
   localparam logic [2:0] HIGH_LEVEL = 3'h4;
   // position of the class selector inside the DS field
   localparam int DS_CLASS_LSB = 3;
   // ingress buffer depth
   localparam int FIFO_DEPTH = 16;
   // fixed weighted round robin ratios, high weight then low weight
   localparam logic [3:0] W4_HIGH = 4'h4;
   localparam logic [3:0] W8_HIGH = 4'h8;
   localparam logic [3:0] WFIX_LOW = 4'h1;
   // reset values
   localparam logic [3:0] RST_WEIGHT_HIGH = 4'h4;
   localparam logic [3:0] RST_WEIGHT_LOW = 4'h1;
   localparam logic [4:0] RST_DEST = 5'h00;

   typedef enum logic [1:0] {SCHED_FIFO, SCHED_STRICT, SCHED_WRR} sched_mode_t;
   typedef enum logic [1:0] {RATIO_4_1, RATIO_8_1, RATIO_ANY} wrr_ratio_t;
endpackage
`default_nettype wire

// ---- logic/port_vlan_qos_scheduler.sv ----
// Operation
// - vlan membership and multi-to-one write invalidate each other
// - excluded ports share one common vlan group
// - multi-to-one acts only in port-based vlan mode
// - configurable destination port, readable back
// - per-port flag excludes port from mapping
// - fifo mode sends frames in arrival order
// - strict mode: waiting high before any low
// - wrr mode serves classes by configured weights
// - eight priority output queues, served per mode
// - wrr ratio 4:1, 8:1 or custom pair
// - one mode setting selects exactly one mode
// - port-based enable makes all port frames high
// - vlan enable derives class from tag priority
// - ip enable derives class from ds field
// - three enable bits for each of eighteen ports
`timescale 1ns/10ps
`default_nettype none

// simple ring buffer; ready on the fill side is honest full
module desc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   // pointers wrap naturally at a power-of-two depth
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // storage needs no reset
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end
endmodule

module port_vlan_qos_scheduler #(
   parameter int TAG_W = 16,
   parameter int QDEPTH = 4,
   parameter int FDEPTH = vlan_qos_pkg::FIFO_DEPTH
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   // configuration staging
   input wire logic APPLY,
   input wire logic PORT_VLAN_MODE,
   input wire logic MEMB_WR,
   input wire logic [4:0] MEMB_PORT,
   input wire logic [17:0] MEMB_MASK,
   input wire logic M21_WR,
   input wire logic [4:0] M21_DEST,
   input wire logic [17:0] M21_EXCL,
   input wire logic [1:0] SCHED_MODE,
   input wire logic [1:0] WRR_RATIO,
   input wire logic [3:0] WEIGHT_HIGH,
   input wire logic [3:0] WEIGHT_LOW,
   input wire logic [17:0] CLS_PORT_EN,
   input wire logic [17:0] CLS_VLAN_EN,
   input wire logic [17:0] CLS_IP_EN,
   // status
   output logic [4:0] CUR_DEST,
   output logic M21_ACTIVE,
   output logic MEMB_ACTIVE,
   // ingress frame descriptors
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [4:0] IN_PORT,
   input wire logic IN_TAGGED,
   input wire logic [2:0] IN_PCP,
   input wire logic IN_IP,
   input wire logic [5:0] IN_DS,
   input wire logic [TAG_W-1:0] IN_TAG,
   // egress frame descriptors
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [17:0] OUT_MASK,
   output logic [2:0] OUT_QUEUE,
   output logic [TAG_W-1:0] OUT_TAG
);
   localparam int NP = vlan_qos_pkg::NUM_PORTS;
   localparam int NQ = vlan_qos_pkg::NUM_QUEUES;
   localparam int DW = TAG_W + NP + vlan_qos_pkg::QUEUE_W;
   localparam int QA = $clog2(QDEPTH);

   // highest set bit of an eight-bit request vector
   function automatic logic [2:0] top_bit(input logic [7:0] req);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 0; i < 8; i++)
         if (req[i])
            idx = 3'(i);
      return idx;
   endfunction

   // staged configuration, written freely by software
   logic [17:0] memb_stage_q [NP];
   logic [4:0] dest_stage_q;
   logic [17:0] excl_stage_q;
   logic memb_stage_ok_q;
   logic m21_stage_ok_q;
   logic [1:0] mode_stage_q;
   logic [1:0] ratio_stage_q;
   logic [3:0] wh_stage_q;
   logic [3:0] wl_stage_q;
   logic [17:0] pen_stage_q;
   logic [17:0] ven_stage_q;
   logic [17:0] ien_stage_q;
   logic pvm_stage_q;
   // active configuration, used by the datapath
   logic [17:0] memb_q [NP];
   logic [4:0] dest_q;
   logic [17:0] excl_q;
   logic memb_ok_q;
   logic m21_ok_q;
   vlan_qos_pkg::sched_mode_t mode_q;
   logic [3:0] wh_q;
   logic [3:0] wl_q;
   logic [17:0] pen_q;
   logic [17:0] ven_q;
   logic [17:0] ien_q;
   logic pvm_q;

   // a later write of either table voids the other one
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         memb_stage_ok_q <= 1'b0;
         m21_stage_ok_q <= 1'b0;
         dest_stage_q <= vlan_qos_pkg::RST_DEST;
         excl_stage_q <= '0;
      end
      else if (M21_WR)
      begin
         dest_stage_q <= M21_DEST;
         excl_stage_q <= M21_EXCL;
         m21_stage_ok_q <= 1'b1;
         memb_stage_ok_q <= 1'b0;
      end
      else if (MEMB_WR)
      begin
         memb_stage_ok_q <= 1'b1;
         m21_stage_ok_q <= 1'b0;
      end
   end

   // membership rows, ports out of range are dropped
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         for (int i = 0; i < NP; i++)
            memb_stage_q[i] <= '1;
      end
      else if (MEMB_WR && !M21_WR && (MEMB_PORT < 5'(NP)))
         memb_stage_q[MEMB_PORT] <= MEMB_MASK;
   end

   // scheduling and classification settings are staged every cycle
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         mode_stage_q <= 2'h0;
         ratio_stage_q <= 2'h0;
         wh_stage_q <= vlan_qos_pkg::RST_WEIGHT_HIGH;
         wl_stage_q <= vlan_qos_pkg::RST_WEIGHT_LOW;
         pen_stage_q <= '0;
         ven_stage_q <= '0;
         ien_stage_q <= '0;
         pvm_stage_q <= 1'b0;
      end
      else
      begin
         mode_stage_q <= SCHED_MODE;
         ratio_stage_q <= WRR_RATIO;
         wh_stage_q <= WEIGHT_HIGH;
         wl_stage_q <= WEIGHT_LOW;
         pen_stage_q <= CLS_PORT_EN;
         ven_stage_q <= CLS_VLAN_EN;
         ien_stage_q <= CLS_IP_EN;
         pvm_stage_q <= PORT_VLAN_MODE;
      end
   end

   // decode of the single mode setting and ratio choice
   wire [1:0] mode_sel = mode_stage_q;
   wire vlan_qos_pkg::sched_mode_t mode_dec = (mode_sel == 2'h1) ? vlan_qos_pkg::SCHED_STRICT :
      (mode_sel == 2'h2) ? vlan_qos_pkg::SCHED_WRR : vlan_qos_pkg::SCHED_FIFO;
   wire [3:0] wh_dec = (ratio_stage_q == 2'h0) ? vlan_qos_pkg::W4_HIGH :
      (ratio_stage_q == 2'h1) ? vlan_qos_pkg::W8_HIGH : wh_stage_q;
   wire [3:0] wl_dec = (ratio_stage_q[1]) ? wl_stage_q : vlan_qos_pkg::WFIX_LOW;

   // commit on apply only, so frames never see a half-written setup
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         for (int i = 0; i < NP; i++)
            memb_q[i] <= '1;
         dest_q <= vlan_qos_pkg::RST_DEST;
         excl_q <= '0;
         memb_ok_q <= 1'b0;
         m21_ok_q <= 1'b0;
         mode_q <= vlan_qos_pkg::SCHED_FIFO;
         wh_q <= vlan_qos_pkg::RST_WEIGHT_HIGH;
         wl_q <= vlan_qos_pkg::RST_WEIGHT_LOW;
         pen_q <= '0;
         ven_q <= '0;
         ien_q <= '0;
         pvm_q <= 1'b0;
      end
      else if (APPLY)
      begin
         memb_q <= memb_stage_q;
         dest_q <= dest_stage_q;
         excl_q <= excl_stage_q;
         memb_ok_q <= memb_stage_ok_q;
         m21_ok_q <= m21_stage_ok_q;
         mode_q <= mode_dec;
         wh_q <= (wh_dec == 4'h0) ? 4'h1 : wh_dec;
         wl_q <= (wl_dec == 4'h0) ? 4'h1 : wl_dec;
         pen_q <= pen_stage_q;
         ven_q <= ven_stage_q;
         ien_q <= ien_stage_q;
         pvm_q <= pvm_stage_q;
      end
   end

   assign CUR_DEST = dest_q;
   assign M21_ACTIVE = m21_ok_q && pvm_q;
   assign MEMB_ACTIVE = memb_ok_q;

   // classification of the arriving frame
   wire port_ok = (IN_PORT < 5'(NP));
   wire [4:0] pidx = port_ok ? IN_PORT : 5'h0;
   wire use_vlan = ven_q[pidx] && IN_TAGGED;
   wire use_ip = ien_q[pidx] && IN_IP;
   wire [2:0] ds_cls = IN_DS[vlan_qos_pkg::DS_CLASS_LSB +: 3];
   wire hi_port = pen_q[pidx];
   wire hi_vlan = use_vlan && (IN_PCP >= vlan_qos_pkg::HIGH_LEVEL);
   wire hi_ip = use_ip && (ds_cls >= vlan_qos_pkg::HIGH_LEVEL);
   wire is_high = hi_port || hi_vlan || hi_ip;
   wire [1:0] level = use_vlan ? IN_PCP[1:0] : (use_ip ? ds_cls[1:0] : 2'h3);
   wire [2:0] cls_queue = {is_high, level};
   // fifo mode funnels everything through one queue to keep arrival order
   wire [2:0] queue_sel = (mode_q == vlan_qos_pkg::SCHED_FIFO) ? 3'h0 : cls_queue;

   // forwarding mask for the frame
   wire [17:0] self_bit = port_ok ? (18'h00001 << pidx) : 18'h00000;
   wire [17:0] dest_bit = (dest_q < 5'(NP)) ? (18'h00001 << dest_q) : 18'h00000;
   wire m21_on = m21_ok_q && pvm_q;
   wire in_excl = |(excl_q & self_bit);
   wire [17:0] m21_mask = in_excl ? (excl_q & ~self_bit) :
      ((self_bit == dest_bit) ? (~excl_q & ~self_bit) : (dest_bit & ~excl_q));
   wire [17:0] memb_mask = memb_q[pidx] & ~self_bit;
   wire [17:0] fwd_mask = m21_on ? m21_mask : (memb_ok_q ? memb_mask : ~self_bit);

   // ingress buffer between classifier and queues
   wire fifo_valid;
   wire fifo_ready;
   wire [DW-1:0] fifo_data;
   desc_fifo #(.WIDTH(DW), .DEPTH(FDEPTH)) u_fifo (
      .clk(SYS_CLK),
      .rst(RESET),
      .in_valid(IN_VALID),
      .in_ready(IN_READY),
      .in_data({IN_TAG, fwd_mask, queue_sel}),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // eight output queues
   logic [DW-1:0] qmem [NQ][QDEPTH];
   logic [QA-1:0] qwr_q [NQ];
   logic [QA-1:0] qrd_q [NQ];
   logic [QA:0] qcnt_q [NQ];
   logic [7:0] q_nonempty;
   logic [7:0] q_full;
   always_comb
   begin
      for (int i = 0; i < NQ; i++)
      begin
         q_nonempty[i] = (qcnt_q[i] != '0);
         q_full[i] = (qcnt_q[i] == (QA+1)'(QDEPTH));
      end
   end

   // a full target queue stalls the buffer, which back-pressures ingress
   wire [2:0] head_q = fifo_data[2:0];
   assign fifo_ready = !q_full[head_q];
   wire enq = fifo_valid && fifo_ready;

   // scheduler selection
   wire [7:0] hi_req = q_nonempty & 8'hF0;
   wire [7:0] lo_req = q_nonempty & 8'h0F;
   logic serve_hi_q;
   logic [3:0] wcnt_q;
   wire pick_hi = (serve_hi_q && (hi_req != 8'h00)) || (lo_req == 8'h00);
   wire [2:0] wrr_pick = pick_hi ? top_bit(hi_req) : top_bit(lo_req);
   wire [2:0] strict_pick = top_bit(q_nonempty);
   wire [2:0] pick = (mode_q == vlan_qos_pkg::SCHED_WRR) ? wrr_pick :
      ((mode_q == vlan_qos_pkg::SCHED_STRICT) ? strict_pick : 3'h0);
   wire out_free = !OUT_VALID || OUT_READY;
   wire deq = out_free && q_nonempty[pick];
   wire pick_is_hi = (pick >= vlan_qos_pkg::HIGH_BASE);

   // queue pointers and occupancy
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         for (int i = 0; i < NQ; i++)
         begin
            qwr_q[i] <= '0;
            qrd_q[i] <= '0;
            qcnt_q[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < NQ; i++)
         begin
            if (enq && (head_q == 3'(i)))
               qwr_q[i] <= qwr_q[i] + 1'b1;
            if (deq && (pick == 3'(i)))
               qrd_q[i] <= qrd_q[i] + 1'b1;
            qcnt_q[i] <= qcnt_q[i] + (QA+1)'(enq && (head_q == 3'(i))) - (QA+1)'(deq && (pick == 3'(i)));
         end
      end
   end

   // queue storage
   always_ff @(posedge SYS_CLK)
   begin
      if (enq)
         qmem[head_q][qwr_q[head_q]] <= fifo_data;
   end

   // weight counter: switch class once the current one used its share
   wire [3:0] cur_w = serve_hi_q ? wh_q : wl_q;
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         serve_hi_q <= 1'b1;
         wcnt_q <= 4'h0;
      end
      else if (deq && (mode_q == vlan_qos_pkg::SCHED_WRR))
      begin
         if ((pick_is_hi != serve_hi_q) || (wcnt_q + 4'h1 >= cur_w))
         begin
            serve_hi_q <= !pick_is_hi;
            wcnt_q <= 4'h0;
         end
         else
            wcnt_q <= wcnt_q + 4'h1;
      end
   end

   // egress holding register
   wire [DW-1:0] sel_word = qmem[pick][qrd_q[pick]];
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         OUT_VALID <= 1'b0;
         OUT_MASK <= '0;
         OUT_QUEUE <= 3'h0;
         OUT_TAG <= '0;
      end
      else if (out_free)
      begin
         OUT_VALID <= deq;
         if (deq)
         begin
            OUT_TAG <= sel_word[DW-1 -: TAG_W];
            OUT_MASK <= sel_word[20:3];
            OUT_QUEUE <= sel_word[2:0];
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/port_vlan_qos_scheduler_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module port_vlan_qos_scheduler_props #(
   parameter int TAG_W = 16
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic APPLY,
   input wire logic PORT_VLAN_MODE,
   input wire logic MEMB_WR,
   input wire logic [4:0] MEMB_PORT,
   input wire logic M21_WR,
   input wire logic [4:0] M21_DEST,
   input wire logic [4:0] CUR_DEST,
   input wire logic M21_ACTIVE,
   input wire logic MEMB_ACTIVE,
   input wire logic IN_READY,
   input wire logic OUT_VALID,
   input wire logic OUT_READY,
   input wire logic [17:0] OUT_MASK,
   input wire logic [2:0] OUT_QUEUE,
   input wire logic [TAG_W-1:0] OUT_TAG
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // a stalled frame stays put and unchanged
   a_hold_valid: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID)
      else $error("frame dropped while stalled");
   a_hold_data: assert property (OUT_VALID && !OUT_READY |=> $stable({OUT_MASK, OUT_QUEUE, OUT_TAG}))
      else $error("frame changed while stalled");
   // status only moves on apply, so half-written settings never leak out
   a_status_stable: assert property (!APPLY |=> $stable({CUR_DEST, M21_ACTIVE, MEMB_ACTIVE}))
      else $error("status moved without apply");
   a_excl_pair: assert property (!(M21_ACTIVE && MEMB_ACTIVE))
      else $error("both mappings active");
   a_dest_apply: assert property (M21_WR ##1 (APPLY && !M21_WR) |=> CUR_DEST == $past(M21_DEST, 2))
      else $error("destination not taken");
   a_m21_voids: assert property (M21_WR ##1 (APPLY && !MEMB_WR && !M21_WR) |=> !MEMB_ACTIVE)
      else $error("membership still active");
   a_memb_voids: assert property ((MEMB_WR && !M21_WR && MEMB_PORT < 5'h12) ##1 (APPLY && !M21_WR)
      |=> MEMB_ACTIVE && !M21_ACTIVE)
      else $error("mapping still active");
   a_mode_off: assert property (!PORT_VLAN_MODE ##1 (APPLY && !PORT_VLAN_MODE) |=> !M21_ACTIVE)
      else $error("mapping active outside port mode");
   a_mode_on: assert property ((M21_WR && PORT_VLAN_MODE) ##1 (APPLY && PORT_VLAN_MODE && !MEMB_WR && !M21_WR)
      |=> M21_ACTIVE)
      else $error("mapping not active");
   // main scenarios
   cover property (OUT_VALID && OUT_READY && OUT_QUEUE[2]);
   cover property (!IN_READY);
   cover property (M21_ACTIVE);
endmodule
bind port_vlan_qos_scheduler port_vlan_qos_scheduler_props #(.TAG_W(TAG_W)) u_props (
   .SYS_CLK(SYS_CLK), .RESET(RESET), .APPLY(APPLY), .PORT_VLAN_MODE(PORT_VLAN_MODE),
   .MEMB_WR(MEMB_WR), .MEMB_PORT(MEMB_PORT), .M21_WR(M21_WR), .M21_DEST(M21_DEST),
   .CUR_DEST(CUR_DEST), .M21_ACTIVE(M21_ACTIVE), .MEMB_ACTIVE(MEMB_ACTIVE), .IN_READY(IN_READY),
   .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_MASK(OUT_MASK), .OUT_QUEUE(OUT_QUEUE),
   .OUT_TAG(OUT_TAG)
);
`default_nettype wire

// ---- dv/egress_sink.sv ----
`timescale 1ns/10ps
`default_nettype none
module egress_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic stall,
   input wire logic slow,
   output logic ready
);
   logic beat_q;
   // a slow port takes every other cycle, stretching the time a frame must stand
   always_ff @(posedge clk)
   begin
      beat_q <= rst ? 1'b0 : !beat_q;
      ready <= !rst && !stall && (!slow || beat_q);
   end
endmodule
`default_nettype wire

// ---- dv/tb_port_vlan_qos_scheduler.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_port_vlan_qos_scheduler;
   localparam int QDEPTH = 4;
   logic clk = 0, rst = 1, apply = 0, pvm = 0, mwr = 0, m21wr = 0, iv = 0, itg = 0, iip = 0;
   logic stall = 0, slow = 0, irdy, ov, ordy, m21a, memba, full_seen = 0;
   logic [1:0] smode = 0, ratio = 0;
   logic [3:0] wh = 4'h3, wl = 4'h2;
   logic [4:0] mport = 0, dest = 0, iport = 0, cdest;
   logic [17:0] mmask = 0, excl = 0, cp = 0, cv = 0, ci = 0, omask;
   logic [2:0] pcp = 0, oq;
   logic [5:0] ds = 0;
   logic [15:0] tag = 0, otag;
   logic [31:0] rnd = 32'hF647;
   logic a_m21 = 0, a_pvm = 0, a_memb = 0, s_m21 = 0, s_memb = 0;
   logic [4:0] a_dest = 0;
   logic [17:0] a_excl = 0, row = 0;
   logic [36:0] notes[$], rq[8][$];
   int num_errors = 0, n_checks = 0, cyc = 0;

   port_vlan_qos_scheduler u_port_vlan_qos_scheduler (
      .SYS_CLK(clk), .RESET(rst), .APPLY(apply), .PORT_VLAN_MODE(pvm), .MEMB_WR(mwr),
      .MEMB_PORT(mport), .MEMB_MASK(mmask), .M21_WR(m21wr), .M21_DEST(dest), .M21_EXCL(excl),
      .SCHED_MODE(smode), .WRR_RATIO(ratio), .WEIGHT_HIGH(wh), .WEIGHT_LOW(wl),
      .CLS_PORT_EN(cp), .CLS_VLAN_EN(cv), .CLS_IP_EN(ci), .CUR_DEST(cdest), .M21_ACTIVE(m21a),
      .MEMB_ACTIVE(memba), .IN_VALID(iv), .IN_READY(irdy), .IN_PORT(iport), .IN_TAGGED(itg),
      .IN_PCP(pcp), .IN_IP(iip), .IN_DS(ds), .IN_TAG(tag), .OUT_VALID(ov), .OUT_READY(ordy),
      .OUT_MASK(omask), .OUT_QUEUE(oq), .OUT_TAG(otag)
   );
   egress_sink u_egress_sink (.clk(clk), .rst(rst), .stall(stall), .slow(slow), .ready(ordy));

   always #25 clk = !clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // forwarding set as the active mapping should give it
   function automatic logic [17:0] xmask(input logic [4:0] p);
      logic [17:0] s;
      s = 18'h1 << p;
      if (a_m21 && a_pvm)
         return a_excl[p] ? a_excl & ~s : p == a_dest ? ~a_excl & ~s : (18'h1 << a_dest) & ~a_excl;
      return ((a_memb && p == 5'h2) ? row : 18'h3FFFF) & ~s;
   endfunction

   // any enabled source marking high wins
   function automatic logic [2:0] xq(input logic [4:0] p, input logic t, input logic [2:0] c,
                                     input logic i, input logic [5:0] d);
      logic h, v, u;
      v = cv[p] && t;
      u = ci[p] && i;
      h = cp[p] || (v && c >= 3'h4) || (u && d[5:3] >= 3'h4);
      if (smode != 2'h1 && smode != 2'h2)
         return 3'h0;
      return {h, v ? c[1:0] : u ? d[4:3] : 2'h3};
   endfunction

   task automatic chk(input string what, input logic [36:0] seen, input logic [36:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // frames that would overflow a queue are skipped so the ordering model stays exact
   task automatic send(input logic [4:0] p, input logic t, input logic i);
      logic [2:0] q;
      rnd = lfsr(rnd);
      q = xq(p, t, rnd[2:0], i, rnd[8:3]);
      if (smode != 2'h0 && rq[q].size() == QDEPTH)
      begin
         // drop the request line, or the previous frame would be taken twice
         iv <= 0;
         @(posedge clk);
         return;
      end
      iv <= 1;
      iport <= p;
      itg <= t;
      iip <= i;
      pcp <= rnd[2:0];
      ds <= rnd[8:3];
      tag <= rnd[31:16];
      if (smode == 2'h1 || smode == 2'h2)
         rq[q].push_back({xmask(p), q, rnd[31:16]});
      else
         notes.push_back({xmask(p), q, rnd[31:16]});
      do @(posedge clk); while (irdy !== 1'b1);
   endtask

   // service order of the scheduler, worked out from the queued frames
   task automatic drain(input int hw, input int lw);
      int c, q;
      logic hi;
      hi = 1;
      c = hw;
      for (int k = 0; k < 60; k++)
      begin
         q = -1;
         for (int j = 0; j < 8; j++)
            if (rq[j].size() != 0 && (smode != 2'h2 || j[2] == hi))
               q = j;
         if (q >= 0)
         begin
            notes.push_back(rq[q].pop_front());
            c--;
         end
         if (smode == 2'h2 && (q < 0 || c == 0))
         begin
            hi = !hi;
            c = hi ? hw : lw;
         end
      end
   endtask

   task automatic do_reset;
      rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      {a_m21, a_memb, s_m21, s_memb} = 0;
   endtask

   task automatic wr_memb(input logic [4:0] p, input logic [17:0] m);
      @(posedge clk);
      mwr <= 1;
      mport <= p;
      mmask <= m;
      @(posedge clk);
      mwr <= 0;
      {s_memb, s_m21} = 2'b10;
      row = m;
   endtask

   task automatic wr_m21(input logic [4:0] d, input logic [17:0] e);
      @(posedge clk);
      m21wr <= 1;
      dest <= d;
      excl <= e;
      @(posedge clk);
      m21wr <= 0;
      {s_memb, s_m21} = 2'b01;
   endtask

   task automatic do_apply;
      apply <= 1;
      {a_m21, a_memb, a_pvm, a_dest, a_excl} = {s_m21, s_memb, pvm, dest, excl};
      @(posedge clk);
      apply <= 0;
   endtask

   task automatic stat(input logic [6:0] e);
      #1;
      chk("status", {cdest, m21a, memba}, e);
      // realign to the rising edge so the next stimulus starts there
      @(posedge clk);
   endtask

   task automatic wait_empty;
      for (int k = 0; k < 400 && notes.size() != 0; k++)
         @(posedge clk);
      repeat (2) @(posedge clk);
   endtask

   task automatic sched(input logic [1:0] m, input logic [1:0] r);
      do_reset;
      smode <= m;
      ratio <= r;
      cp <= 18'h10;
      cv <= 18'h50;
      ci <= 18'h111;
      stall <= 1;
      repeat (2) @(posedge clk);
      do_apply;
      send(5'h4, 0, 0);
      iv <= 0;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 16; k++)
         send(5'(2 * (rnd % 5)), rnd[7], rnd[9]);
      iv <= 0;
      repeat (6) @(posedge clk);
      drain(r == 0 ? 4 : r == 1 ? 8 : 3, r > 1 ? 2 : 1);
      slow <= r[0];
      stall <= 0;
      wait_empty;
   endtask

   // sink side: each accepted frame is matched against the oldest note
   always @(posedge clk)
   begin
      cyc++;
      if (irdy === 1'b0)
         full_seen = 1;
      if (!rst && ov === 1'b1 && ordy === 1'b1)
         chk("frame", {omask, oq, otag}, notes.size() != 0 ? notes.pop_front() : 'x);
      // the ceiling comes last so nothing runs after the closing report
      if (cyc == 20000)
      begin
         num_errors++;
         test_done;
      end
   end

   // fifo order with a slow and then a stalled sink, mapping tables, then each scheduler
   initial
   begin
      do_reset;
      stat(7'h00);
      slow <= 1;
      repeat (6)
         send(5'(rnd % 18), rnd[5], rnd[6]);
      stall <= 1;
      fork
         begin
            repeat (40) @(posedge clk);
            stall <= 0;
         end
      join_none
      repeat (24)
         send(5'(rnd % 18), rnd[5], rnd[6]);
      iv <= 0;
      chk("refused", full_seen, 1);
      wait_empty;
      slow <= 0;
      wr_memb(5'h2, 18'h2A5F6);
      do_apply;
      stat(7'h01);
      send(5'h2, 0, 0);
      send(5'h9, 0, 0);
      iv <= 0;
      pvm <= 1;
      wr_m21(5'h5, 18'h0000A);
      do_apply;
      stat(7'h16);
      send(5'h1, 1, 1);
      send(5'h5, 0, 0);
      send(5'h7, 0, 1);
      iv <= 0;
      pvm <= 0;
      repeat (2) @(posedge clk);
      do_apply;
      stat(7'h14);
      send(5'h7, 0, 0);
      iv <= 0;
      wait_empty;
      for (int m = 1; m < 3; m++)
         for (int r = 0; r < 4; r++)
            sched(2'(m), 2'(r));
      // the spare mode code must behave as plain arrival order
      sched(2'h3, 2'h0);
      chk("left", 37'(notes.size()), 0);
      test_done;
   end
endmodule
`default_nettype wire
